/* rtl/dchp_port.sv */
// Top of the host and buffer port: DMA handshake, register port and drive inputs.
`timescale 1ns/1ps
module dchp_port #(
  parameter int SECTOR_BYTES = dchp_pkg::SECTOR_BYTES_DEF
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic acknowledge_n_in,
  input wire logic stop_n_in,
  input wire logic port_location_select_in,
  input wire logic register_access_select_n_in,
  input wire logic write_not_read_in,
  input wire logic [dchp_pkg::BYTE_W-1:0] byte_bus_in,
  input wire dchp_pkg::dchp_pins_t drive_pins_in,
  input wire logic op_start_in,
  input wire logic op_write_in,
  input wire logic disk_byte_valid_in,
  input wire logic [dchp_pkg::BYTE_W-1:0] disk_byte_in,
  input wire logic disk_byte_take_in,
  output logic request_n_out,
  output logic [dchp_pkg::BYTE_W-1:0] byte_bus_out,
  output logic byte_bus_oe_out,
  output logic busy_out,
  output logic [dchp_pkg::BYTE_W-1:0] disk_byte_out,
  output logic sector_start_out,
  output logic [dchp_pkg::BYTE_W-1:0] sector_number_out,
  output dchp_pkg::dchp_wr_t reg_write_out
);

  localparam int CNT_W = $clog2(SECTOR_BYTES + 1);
  localparam logic [CNT_W-1:0] LAST_BYTE = CNT_W'(SECTOR_BYTES - 1);

  dchp_pkg::dchp_state_t state_reg;
  dchp_pkg::dchp_pins_t pin_level;
  dchp_pkg::dchp_pins_t pin_rise;
  dchp_pkg::dchp_cpu_t cpu;
  logic write_op_reg;
  logic stop_seen_reg;
  logic overrun_reg;
  logic hold_valid_reg;
  logic [dchp_pkg::BYTE_W-1:0] hold_byte_reg;
  logic [CNT_W-1:0] byte_count_reg;
  logic request_n_reg;
  logic [dchp_pkg::BYTE_W-1:0] bus_data_reg;
  logic bus_oe_reg;
  logic sector_start_reg;
  logic [dchp_pkg::BYTE_W-1:0] sector_number_reg;
  logic [dchp_pkg::BYTE_W-1:0] disk_byte_reg;
  logic ack_cycle;
  logic disk_step;
  logic sector_end;
  logic op_end;
  logic busy_reg;
  logic sector_edge;
  logic cpu_read;
  logic [dchp_pkg::BYTE_W-1:0] cpu_read_data;
  logic [dchp_pkg::BYTE_W-1:0] status_byte;
  logic [dchp_pkg::BYTE_W-1:0] drive_status_byte;
  logic [dchp_pkg::BYTE_W-1:0] xfer_status_byte;

  ////////////////////////////////////////////////////////////////////////////
  // Drive pins are asynchronous, so each passes two flops first.
  dchp_sync #(
    .WIDTH($bits(dchp_pkg::dchp_pins_t))
  ) u_pin_sync (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .async_in(drive_pins_in),
    .level_out(pin_level),
    .rise_out(pin_rise)
  );

  assign cpu.select_n = register_access_select_n_in;
  assign cpu.location = port_location_select_in;
  assign cpu.write_not_read = write_not_read_in;
  assign cpu.data = byte_bus_in;

  dchp_host_port u_host_port (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .cpu_in(cpu),
    .status_in(status_byte),
    .drive_status_in(drive_status_byte),
    .xfer_status_in(xfer_status_byte),
    .cpu_read_out(cpu_read),
    .cpu_read_data_out(cpu_read_data),
    .wr_out(reg_write_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Readable bytes.
  always_comb
  begin
    status_byte = dchp_pkg::BYTE_ZERO;
    status_byte[dchp_pkg::STAT_SHARED_A_BIT] = pin_level.shared_a;
    status_byte[dchp_pkg::STAT_SHARED_B_BIT] = pin_level.shared_b;
    status_byte[dchp_pkg::STAT_BUSY_BIT] = busy_out;
    drive_status_byte = dchp_pkg::BYTE_ZERO;
    drive_status_byte[dchp_pkg::DRV_READY_BIT] = pin_level.ready;
    drive_status_byte[dchp_pkg::DRV_SELECTED_BIT] = pin_level.selected;
    xfer_status_byte = dchp_pkg::BYTE_ZERO;
    xfer_status_byte[dchp_pkg::XFER_OVERRUN_BIT] = overrun_reg;
  end

  ////////////////////////////////////////////////////////////////////////////
  // acknowledge sampled at the rising edge.
  // one sampled low level is one byte.
  assign ack_cycle = !acknowledge_n_in && state_reg == dchp_pkg::DCHP_XFER;
  assign disk_step = write_op_reg ? disk_byte_take_in : disk_byte_valid_in;
  assign sector_end = state_reg == dchp_pkg::DCHP_XFER && disk_step &&
                      byte_count_reg == LAST_BYTE;
  assign op_end = sector_end && (stop_seen_reg || overrun_reg);
  // hard sector pulse; the index pulse also starts a sector.
  assign sector_edge = pin_rise.index || pin_rise.sector;

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      sector_start_reg <= 1'b0;
      sector_number_reg <= dchp_pkg::BYTE_ZERO;
    end
    else
    begin
      sector_start_reg <= sector_edge;
      if (pin_rise.index)
        sector_number_reg <= dchp_pkg::BYTE_ZERO;
      else if (pin_rise.sector)
        sector_number_reg <= sector_number_reg + 8'h01;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      state_reg <= dchp_pkg::DCHP_IDLE;
      busy_reg <= 1'b0;
    end
    else
    begin
      unique case (state_reg)
        dchp_pkg::DCHP_IDLE:
          if (op_start_in)
          begin
            state_reg <= dchp_pkg::DCHP_WAIT_SECTOR;
            busy_reg <= 1'b1;
          end
        dchp_pkg::DCHP_WAIT_SECTOR:
          if (sector_edge)
            state_reg <= dchp_pkg::DCHP_XFER;
        dchp_pkg::DCHP_XFER:
          if (op_end)
          begin
            state_reg <= dchp_pkg::DCHP_IDLE;
            busy_reg <= 1'b0;
          end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
      write_op_reg <= 1'b0;
    else if (state_reg == dchp_pkg::DCHP_IDLE && op_start_in)
      write_op_reg <= op_write_in;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
      stop_seen_reg <= 1'b0;
    else if (ack_cycle && !stop_n_in)
      stop_seen_reg <= 1'b1;
    else if (state_reg == dchp_pkg::DCHP_IDLE)
      stop_seen_reg <= 1'b0;
  end

  // set wins over the clear at a new start.
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
      overrun_reg <= 1'b0;
    else if (state_reg == dchp_pkg::DCHP_XFER && !stop_seen_reg &&
             (write_op_reg ? disk_byte_take_in && !hold_valid_reg
                           : disk_byte_valid_in && hold_valid_reg && !ack_cycle))
      overrun_reg <= 1'b1;
    else if (state_reg == dchp_pkg::DCHP_IDLE && op_start_in)
      overrun_reg <= 1'b0;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
      byte_count_reg <= '0;
    else if (state_reg != dchp_pkg::DCHP_XFER || sector_end)
      byte_count_reg <= '0;
    else if (disk_step)
      byte_count_reg <= byte_count_reg + CNT_W'(1);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Holding byte between disk and buffer.
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      hold_valid_reg <= 1'b0;
      hold_byte_reg <= dchp_pkg::BYTE_ZERO;
    end
    else if (state_reg != dchp_pkg::DCHP_XFER)
      hold_valid_reg <= 1'b0;
    else if (write_op_reg)
    begin
      if (ack_cycle)
      begin
        hold_valid_reg <= 1'b1;
        hold_byte_reg <= byte_bus_in;
      end
      else if (disk_byte_take_in)
        hold_valid_reg <= 1'b0;
    end
    else
    begin
      // A late byte overwrites the held one; the lost byte is flagged unless a stop was seen, and is not kept.
      if (disk_byte_valid_in)
      begin
        hold_valid_reg <= 1'b1;
        hold_byte_reg <= disk_byte_in;
      end
      else if (ack_cycle)
        hold_valid_reg <= 1'b0;
    end
  end

  // the last byte stays until replaced, so padding repeats it.
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
      disk_byte_reg <= dchp_pkg::BYTE_ZERO;
    else if (write_op_reg && disk_byte_take_in && hold_valid_reg)
      disk_byte_reg <= hold_byte_reg;
  end

  // request when a byte waits or is wanted.
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
      request_n_reg <= 1'b1;
    // Released on the ending step too, so no request outlives busy.
    else if (ack_cycle || stop_seen_reg || op_end || state_reg != dchp_pkg::DCHP_XFER)
      request_n_reg <= 1'b1;
    else
      request_n_reg <= write_op_reg ? hold_valid_reg : !hold_valid_reg;
  end

  // read byte driven for the acknowledged byte.
  // bus levels change only at the clock edge.
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      bus_oe_reg <= 1'b0;
      bus_data_reg <= dchp_pkg::BYTE_ZERO;
    end
    else if (ack_cycle && !write_op_reg)
    begin
      bus_oe_reg <= 1'b1;
      bus_data_reg <= hold_byte_reg;
    end
    else
    begin
      bus_oe_reg <= cpu_read && acknowledge_n_in;
      bus_data_reg <= cpu_read_data;
    end
  end

  assign request_n_out = request_n_reg;
  assign byte_bus_out = bus_data_reg;
  assign byte_bus_oe_out = bus_oe_reg;
  assign busy_out = busy_reg;
  assign disk_byte_out = disk_byte_reg;
  assign sector_start_out = sector_start_reg;
  assign sector_number_out = sector_number_reg;

endmodule : dchp_port

/* rtl/dchp_pkg.sv */
// Shared constants and carrier types for the disk controller host and DMA port.
package dchp_pkg;

  localparam int BYTE_W = 8;
  localparam int PTR_W = 6;
  localparam int SECTOR_BYTES_DEF = 512;

  // Register pointer values that the port decodes itself.
  localparam logic [PTR_W-1:0] REG_DRIVE_STATUS = 6'h04;
  localparam logic [PTR_W-1:0] REG_XFER_STATUS = 6'h05;

  // Bit positions inside the readable bytes.
  localparam int DRV_READY_BIT = 6;
  localparam int DRV_SELECTED_BIT = 7;
  localparam int XFER_OVERRUN_BIT = 1;
  localparam int STAT_SHARED_A_BIT = 2;
  localparam int STAT_SHARED_B_BIT = 1;
  localparam int STAT_BUSY_BIT = 0;

  localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
  localparam logic PORT_POINTER = 1'b0;
  localparam logic PORT_DATA = 1'b1;

  // Drive-side pins, all asynchronous to the buffer clock.
  typedef struct packed {
    logic index;
    logic sector;
    logic ready;
    logic selected;
    logic shared_a;
    logic shared_b;
  } dchp_pins_t;

  // One processor register cycle as seen on the pins.
  typedef struct packed {
    logic select_n;
    logic location;
    logic write_not_read;
    logic [BYTE_W-1:0] data;
  } dchp_cpu_t;

  // A register write leaving the port for the rest of the chip.
  typedef struct packed {
    logic strobe;
    logic [PTR_W-1:0] addr;
    logic [BYTE_W-1:0] data;
  } dchp_wr_t;

  typedef enum logic [1:0] {
    DCHP_IDLE,
    DCHP_WAIT_SECTOR,
    DCHP_XFER
  } dchp_state_t;

endpackage : dchp_pkg

/* rtl/dchp_sync.sv */
// Two-flop synchroniser with a rising edge detector behind it.
`timescale 1ns/1ps
module dchp_sync #(
  parameter int WIDTH = 6
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] level_out,
  output logic [WIDTH-1:0] rise_out
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] level_reg;
  logic [WIDTH-1:0] prev_reg;

  // Only the second flop and beyond are read, so the first may go metastable.
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      meta_reg <= '0;
      level_reg <= '0;
      prev_reg <= '0;
    end
    else
    begin
      meta_reg <= async_in;
      level_reg <= meta_reg;
      prev_reg <= level_reg;
    end
  end

  assign level_out = level_reg;
  assign rise_out = level_reg & ~prev_reg;

endmodule : dchp_sync

/* rtl/dchp_host_port.sv */
// Processor register port: pointer, data location decode and read selection.
`timescale 1ns/1ps
module dchp_host_port (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire dchp_pkg::dchp_cpu_t cpu_in,
  input wire logic [dchp_pkg::BYTE_W-1:0] status_in,
  input wire logic [dchp_pkg::BYTE_W-1:0] drive_status_in,
  input wire logic [dchp_pkg::BYTE_W-1:0] xfer_status_in,
  output logic cpu_read_out,
  output logic [dchp_pkg::BYTE_W-1:0] cpu_read_data_out,
  output dchp_pkg::dchp_wr_t wr_out
);

  logic [dchp_pkg::PTR_W-1:0] pointer_reg;
  logic cpu_write;

  assign cpu_write = !cpu_in.select_n && !cpu_in.write_not_read;
  assign cpu_read_out = !cpu_in.select_n && cpu_in.write_not_read;

  ////////////////////////////////////////////////////////////////////////////
  // pointer written at low location.
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
      pointer_reg <= '0;
    else if (cpu_write && cpu_in.location == dchp_pkg::PORT_POINTER)
      pointer_reg <= cpu_in.data[dchp_pkg::PTR_W-1:0];
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
      wr_out <= '0;
    else
    begin
      wr_out.strobe <= cpu_write && cpu_in.location == dchp_pkg::PORT_DATA;
      wr_out.addr <= pointer_reg;
      wr_out.data <= cpu_in.data;
    end
  end

  // low reads status, high reads drive or transfer status by pointer, else zero.
  always_comb
  begin
    cpu_read_data_out = dchp_pkg::BYTE_ZERO;
    if (cpu_in.location == dchp_pkg::PORT_POINTER)
      cpu_read_data_out = status_in;
    else if (pointer_reg == dchp_pkg::REG_DRIVE_STATUS)
      cpu_read_data_out = drive_status_in;
    else if (pointer_reg == dchp_pkg::REG_XFER_STATUS)
      cpu_read_data_out = xfer_status_in;
  end

endmodule : dchp_host_port

/* dv/dchp_port_properties.sv */
// Concurrent checks on the host and buffer port pins.
`timescale 1ns/1ps
module dchp_port_properties #(
  parameter int SECTOR_BYTES = 4
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic acknowledge_n_in,
  input wire logic stop_n_in,
  input wire logic port_location_select_in,
  input wire logic register_access_select_n_in,
  input wire logic write_not_read_in,
  input wire logic [dchp_pkg::BYTE_W-1:0] byte_bus_in,
  input wire logic op_start_in,
  input wire logic op_write_in,
  input wire logic request_n_out,
  input wire logic [dchp_pkg::BYTE_W-1:0] byte_bus_out,
  input wire logic byte_bus_oe_out,
  input wire logic busy_out,
  input wire dchp_pkg::dchp_wr_t reg_write_out
);
  logic wr_mode_reg;
  logic stop_seen_reg;
  wire logic sel = !register_access_select_n_in;
  wire logic ack_take = !acknowledge_n_in && !request_n_out;
  wire logic cpu_wr = sel && port_location_select_in && !write_not_read_in;
  wire logic cpu_rd = sel && write_not_read_in && acknowledge_n_in;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  always_ff @(posedge clk_sys_in)
    if (!rst_n_in)
      wr_mode_reg <= 1'b0;
    else if (op_start_in && !busy_out)
      wr_mode_reg <= op_write_in;
  // A stop counts only when it rides on an acknowledged byte.
  always_ff @(posedge clk_sys_in)
    if (!rst_n_in || !busy_out)
      stop_seen_reg <= 1'b0;
    else if (ack_take && !stop_n_in)
      stop_seen_reg <= 1'b1;
  ////////////////////////////////////////////////////////////////////////////
  a_req_release: assert property (ack_take |=> request_n_out)
    else $error("request held after acknowledge");
  a_req_busy: assert property (!request_n_out |-> busy_out)
    else $error("request outside an operation");
  a_read_gate: assert property (ack_take && !wr_mode_reg |=> byte_bus_oe_out)
    else $error("read byte not driven");
  a_stop_quiet: assert property (stop_seen_reg |-> request_n_out)
    else $error("request after stop");
  a_cpu_read: assert property (cpu_rd |=> byte_bus_oe_out)
    else $error("register read not driven");
  a_idle_bus: assert property ((!sel || !write_not_read_in) && acknowledge_n_in
    |=> !byte_bus_oe_out)
    else $error("bus driven without a read");
  a_busy_bit: assert property (cpu_rd && !port_location_select_in
    |=> byte_bus_out[dchp_pkg::STAT_BUSY_BIT] == $past(busy_out))
    else $error("status busy bit wrong");
  a_reg_write: assert property (cpu_wr
    |=> reg_write_out.strobe && reg_write_out.data == $past(byte_bus_in))
    else $error("register write lost");
  a_strobe_cause: assert property (reg_write_out.strobe |-> $past(cpu_wr))
    else $error("write strobe without a write");
  a_busy_start: assert property ($rose(busy_out) |-> $past(op_start_in))
    else $error("busy without a start");
  c_stop: cover property (ack_take && !stop_n_in);
  c_write: cover property (reg_write_out.strobe);
  c_done: cover property ($fell(busy_out));
endmodule : dchp_port_properties

bind dchp_port dchp_port_properties #(.SECTOR_BYTES(SECTOR_BYTES)) u_props (
  .clk_sys_in, .rst_n_in, .acknowledge_n_in, .stop_n_in, .port_location_select_in,
  .register_access_select_n_in, .write_not_read_in, .byte_bus_in, .op_start_in,
  .op_write_in, .request_n_out, .byte_bus_out, .byte_bus_oe_out, .busy_out, .reg_write_out
);

/* dv/dchp_buf_model.sv */
// Behavioural buffer controller that answers the DMA request line.
`timescale 1ns/1ps
module dchp_buf_model (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic request_n_in,
  input wire logic enable_in,
  input wire logic stop_req_in,
  input wire logic stray_stop_in,
  input wire logic [1:0] delay_in,
  output logic acknowledge_n_out,
  output logic stop_n_out,
  output logic drive_out,
  output logic [7:0] data_out
);
  logic [1:0] wait_reg;
  always @(posedge clk_sys_in)
    if (!rst_n_in || !acknowledge_n_out || request_n_in || !enable_in)
    begin
      acknowledge_n_out <= 1'b1;
      stop_n_out <= !stray_stop_in;
      drive_out <= 1'b0;
      data_out <= ~data_out;
      wait_reg <= 2'h0;
    end
    else if (wait_reg != delay_in)
      wait_reg <= wait_reg + 2'h1;
    else
    begin
      acknowledge_n_out <= 1'b0;
      stop_n_out <= !stop_req_in;
      drive_out <= 1'b1;
      data_out <= 8'($urandom);
    end
endmodule : dchp_buf_model

/* dv/dchp_port_tb.sv */
// Self-checking bench for the host and buffer port.
`timescale 1ns/1ps
module dchp_port_tb;
  localparam int SECTOR_BYTES = 4;
  localparam int STOP_AT = 2;
  logic clk_sys_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic sel_n = 1'b1, loc = 1'b0, wnr = 1'b1, op_start = 1'b0, op_write = 1'b0;
  logic dvalid = 1'b0, dtake = 1'b0, m_en = 1'b1, stop_req = 1'b0, stray = 1'b0;
  logic [7:0] cpu_data = 8'h00, dbyte = 8'h00;
  logic [1:0] dly = 2'h0;
  dchp_pkg::dchp_pins_t pins = '0;
  logic ack_n, stop_n, m_drive, req_n, oe, busy, sec_start, rd_pend = 1'b0;
  logic [7:0] m_data, bus_out, dbyte_out, sec_num;
  wire logic [7:0] bus_in = m_drive ? m_data : cpu_data;
  dchp_pkg::dchp_wr_t wr;
  int n_ack = 0, n_sec = 0, mismatches = 0, tests_run = 0;
  logic [7:0] rd_q[$];
  logic [7:0] wq[$];
  always #20 clk_sys_in = ~clk_sys_in;
  dchp_port #(.SECTOR_BYTES(SECTOR_BYTES)) DUT (
    .clk_sys_in, .rst_n_in, .acknowledge_n_in(ack_n), .stop_n_in(stop_n),
    .port_location_select_in(loc), .register_access_select_n_in(sel_n),
    .write_not_read_in(wnr), .byte_bus_in(bus_in), .drive_pins_in(pins),
    .op_start_in(op_start), .op_write_in(op_write), .disk_byte_valid_in(dvalid),
    .disk_byte_in(dbyte), .disk_byte_take_in(dtake), .request_n_out(req_n),
    .byte_bus_out(bus_out), .byte_bus_oe_out(oe), .busy_out(busy),
    .disk_byte_out(dbyte_out), .sector_start_out(sec_start),
    .sector_number_out(sec_num), .reg_write_out(wr));
  dchp_buf_model u_buf (.clk_sys_in, .rst_n_in, .request_n_in(req_n), .enable_in(m_en),
    .stop_req_in(stop_req), .stray_stop_in(stray), .delay_in(dly),
    .acknowledge_n_out(ack_n), .stop_n_out(stop_n), .drive_out(m_drive), .data_out(m_data));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1)
    begin
      mismatches++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask : check
  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : final_report
  task automatic cpu(input logic l, input logic w, input logic [7:0] d);
    @(posedge clk_sys_in);
    sel_n <= 1'b0;
    loc <= l;
    wnr <= w;
    cpu_data <= d;
    @(posedge clk_sys_in);
    sel_n <= 1'b1;
    wnr <= 1'b1;
    cpu_data <= ~d;
    #1;
  endtask : cpu
  task automatic rd_reg(input logic [5:0] p);
    cpu(1'b0, 1'b0, {2'h0, p});
    cpu(1'b1, 1'b1, 8'h00);
    check(oe === 1'b1, "data read not driven");
  endtask : rd_reg
  task automatic pulse(input int b);
    @(posedge clk_sys_in);
    pins[b] <= 1'b1;
    repeat (6) @(posedge clk_sys_in);
    pins[b] <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    #1;
  endtask : pulse
  task automatic start_op(input logic w);
    rd_q.delete();
    wq.delete();
    @(posedge clk_sys_in);
    op_start <= 1'b1;
    op_write <= w;
    n_ack <= 0;
    dly <= 2'($urandom);
    @(posedge clk_sys_in);
    op_start <= 1'b0;
    pulse(4);
    check(busy === 1'b1, "busy low in operation");
  endtask : start_op
  task automatic wait_ack(input int n);
    for (int i = 0; i < 200 && n_ack < n; i++)
      @(posedge clk_sys_in);
    check(n_ack >= n, "no acknowledged byte");
  endtask : wait_ack
  task automatic feed;
    @(posedge clk_sys_in);
    dvalid <= 1'b1;
    dbyte <= 8'($urandom);
    @(posedge clk_sys_in);
    dvalid <= 1'b0;
    rd_q.push_back(dbyte);
  endtask : feed
  task automatic wait_idle(input string name);
    for (int i = 0; i < 12 && busy !== 1'b0; i++)
      @(posedge clk_sys_in);
    check(busy === 1'b0, "operation did not end");
    $display("Test %s done", name);
  endtask : wait_idle
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys_in)
  begin
    if (sec_start === 1'b1)
      n_sec <= n_sec + 1;
    if (rd_pend)
      check(oe === 1'b1 && bus_out === rd_q.pop_front(), "read byte wrong");
    rd_pend <= 1'b0;
    if (rst_n_in && !ack_n && !req_n)
    begin
      n_ack <= n_ack + 1;
      stop_req <= (n_ack + 2 == STOP_AT);
      rd_pend <= !op_write;
      wq.push_back(bus_in);
    end
  end
  initial
  begin
    #(40 * 20000);
    mismatches++;
    final_report();
  end
  initial
  begin
    logic [5:0] p;
    logic [7:0] d;
    int k;
    void'($urandom(1488));
    repeat (2) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    #1;
    check(req_n === 1'b1 && oe === 1'b0 && busy === 1'b0, "reset state");
    for (int i = 0; i < 4; i++)
    begin
      p = 6'($urandom);
      d = 8'($urandom);
      cpu(1'b0, 1'b0, {2'h0, p});
      cpu(1'b1, 1'b0, d);
      check(wr.strobe === 1'b1 && wr.addr === p && wr.data === d, "register write");
    end
    @(posedge clk_sys_in);
    wnr <= 1'b0;
    @(posedge clk_sys_in);
    wnr <= 1'b1;
    #1;
    check(wr.strobe === 1'b0, "write without select");
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk_sys_in);
      {pins.ready, pins.selected, pins.shared_a, pins.shared_b} <= 4'($urandom);
      repeat (4) @(posedge clk_sys_in);
      cpu(1'b0, 1'b1, 8'h00);
      check(bus_out[2:0] === {pins.shared_a, pins.shared_b, 1'b0}, "status");
      rd_reg(dchp_pkg::REG_DRIVE_STATUS);
      check(bus_out[7:6] === {pins.selected, pins.ready}, "drive status");
    end
    $display("Test registers done");
    k = n_sec;
    for (int j = 0; j < 3; j++)
    begin
      pulse(j == 0 ? 5 : 4);
      check(sec_num === 8'(j) && n_sec == k + j + 1, "sector count");
    end
    $display("Test sectors done");
    start_op(1'b0);
    @(posedge clk_sys_in);
    stray <= 1'b1;
    for (int i = 0; i < SECTOR_BYTES; i++)
    begin
      feed();
      if (i < STOP_AT)
        wait_ack(i + 1);
      else
        repeat (6) @(posedge clk_sys_in);
    end
    stray <= 1'b0;
    wait_idle("dma read");
    check(n_ack == STOP_AT, "request after stop");
    start_op(1'b1);
    for (int i = 0; i < SECTOR_BYTES; i++)
    begin
      if (i < STOP_AT)
        wait_ack(i + 1);
      @(posedge clk_sys_in);
      dtake <= 1'b1;
      @(posedge clk_sys_in);
      dtake <= 1'b0;
      #1;
      check(dbyte_out === wq[i < STOP_AT ? i : STOP_AT - 1], "disk byte");
    end
    wait_idle("dma write");
    rd_reg(dchp_pkg::REG_XFER_STATUS);
    check(bus_out[1] === 1'b0, "padding flagged overrun");
    @(posedge clk_sys_in);
    m_en <= 1'b0;
    start_op(1'b0);
    feed();
    feed();
    rd_reg(dchp_pkg::REG_XFER_STATUS);
    check(bus_out[1] === 1'b1, "overrun not flagged");
    cpu(1'b0, 1'b1, 8'h00);
    check(oe === 1'b1 && bus_out[0] === 1'b1, "busy status bit");
    feed();
    feed();
    wait_idle("overrun");
    final_report();
  end
endmodule : dchp_port_tb
